// ### hw/eic_pkg.sv
// Behaviour
// - Accepting any interrupt clears global enable; a return in the same cycle sets it instead.
// - Return instruction sets global enable again.
// - Taking vector clears the causing source flag.
// - Flags set and hold even when masked.
// - Pending requests wait, then served by priority.
// - Level request unlatched, active while pin low.
// - Status register not saved nor restored.
// - Request one needs mask bit 7, vector 002.
// - Request zero needs mask bit 6, vector 001.
// - Two sense bits select rise, fall, level.
// - Pin activity counts even when driven output.
// - Selected edge sets flag bit 7 or 6.
// - Writing one clears flag, zero does nothing.
// - Level sensing holds the pin flag cleared.
// - Mask and flag bits 5..0 read zero.
// - Vector executes at least four cycles after flag.
// - One main instruction runs after return first.
package eic_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] OFF_MASK = 8'h00;
   localparam logic [7:0] OFF_FLAG = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_PSTAT = 8'h0C;
   localparam logic [7:0] OFF_ISTAT = 8'h10;
   localparam logic [7:0] OFF_ICLR = 8'h14;
   localparam logic [7:0] OFF_IEN = 8'h18;
   localparam int EXT_FIELD_LSB = 6;
   localparam int GIE_BIT = 7;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic [1:0] FLAG_RST = 2'h0;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic GIE_RST = 1'b0;
   localparam logic [2:0] IRQ_RST = 3'h0;
   localparam logic PIN_IDLE = 1'b1;
   // ****************************************
   // Sense modes and vectors
   // ****************************************
   localparam logic [1:0] SENSE_LEVEL = 2'h0;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   localparam logic [11:0] VEC_ZERO = 12'h001;
   localparam logic [11:0] VEC_ONE = 12'h002;
   localparam int ENTRY_CYCLES = 4;
   typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_GAP} eic_state_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } eic_apb_s;
   typedef struct packed {
      logic valid;
      logic [11:0] addr;
   } eic_vec_s;
endpackage

// ### hw/eic_top.sv
`timescale 1ns/1ns
module eic_top #(
   parameter int ENTRY_CYCLES = eic_pkg::ENTRY_CYCLES
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire eic_pkg::eic_apb_s apb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [1:0] ext_pin_in,
   input wire logic boundary_in,
   input wire logic return_from_irq_instr_in,
   input wire logic instr_done_in,
   output logic take_out,
   output eic_pkg::eic_vec_s vec_out,
   output logic gie_out,
   output logic irq_out
);
   if (ENTRY_CYCLES < 4 || ENTRY_CYCLES > 255) begin : g_chk
      $error("ENTRY_CYCLES must lie in 4..255");
   end

   // ****************************************
   // Bus decode
   // ****************************************
   logic setup_w, wr_w, mapped_w;
   logic [7:0] addr_w;
   logic [31:0] wd_w;
   logic [31:0] prdata_reg;
   logic [1:0] mask_reg, flag_reg, edge_w, level_w, lvl_w, req_w, w1c_w, clrv_w;
   logic [3:0] ctrl_reg;
   logic gie_reg, accept_w, fire_w, src_reg;
   logic [2:0] istat_reg, ien_reg, ev_w;
   logic [7:0] cnt_reg;
   eic_pkg::eic_state_e state_reg;
   eic_pkg::eic_vec_s vec_reg;
   logic take_reg;

   assign addr_w = apb_in.paddr;
   assign wd_w = apb_in.pwdata;
   assign setup_w = apb_in.psel && !apb_in.penable;
   assign wr_w = apb_in.psel && apb_in.penable && apb_in.pwrite && mapped_w;
   always_comb begin
      case (addr_w)
         eic_pkg::OFF_MASK, eic_pkg::OFF_FLAG, eic_pkg::OFF_CTRL, eic_pkg::OFF_PSTAT,
         eic_pkg::OFF_ISTAT, eic_pkg::OFF_ICLR, eic_pkg::OFF_IEN: mapped_w = 1'b1;
         default: mapped_w = 1'b0;
      endcase
   end
   assign pready_out = 1'b1;
   assign pslverr_out = apb_in.psel && apb_in.penable && !mapped_w;

   // Read data is captured in the setup cycle so the access phase needs no wait state.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_reg <= 32'h0;
      end else if (setup_w && !apb_in.pwrite) begin
         case (addr_w)
            eic_pkg::OFF_MASK: prdata_reg <= {24'h0, mask_reg, 6'h0};
            eic_pkg::OFF_FLAG: prdata_reg <= {24'h0, flag_reg, 6'h0};
            eic_pkg::OFF_CTRL: prdata_reg <= {28'h0, ctrl_reg};
            eic_pkg::OFF_PSTAT: prdata_reg <= {24'h0, gie_reg, 7'h0};
            eic_pkg::OFF_ISTAT: prdata_reg <= {29'h0, istat_reg};
            eic_pkg::OFF_IEN: prdata_reg <= {29'h0, ien_reg};
            default: prdata_reg <= 32'h0;
         endcase
      end
   end
   assign prdata_out = prdata_reg;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mask_reg <= eic_pkg::MASK_RST;
         ctrl_reg <= eic_pkg::CTRL_RST;
         ien_reg <= eic_pkg::IRQ_RST;
      end else if (wr_w) begin
         if (addr_w == eic_pkg::OFF_MASK) begin
            mask_reg <= wd_w[eic_pkg::EXT_FIELD_LSB +: 2];
         end
         if (addr_w == eic_pkg::OFF_CTRL) begin
            ctrl_reg <= wd_w[3:0];
         end
         if (addr_w == eic_pkg::OFF_IEN) begin
            ien_reg <= wd_w[2:0];
         end
      end
   end

   // ****************************************
   // Pin sampling and sensing
   // ****************************************
   for (genvar g = 0; g < 2; g++) begin : g_pin
      logic [2:0] sh_reg;
      logic lvl_reg, prev_reg;
      logic [1:0] sense_w;
      assign sense_w = ctrl_reg[2*g +: 2];
      // The pad level is sampled whatever the pin direction is.
      always_ff @(posedge clk_in or negedge rstn_in) begin
         if (!rstn_in) begin
            sh_reg <= {3{eic_pkg::PIN_IDLE}};
            lvl_reg <= eic_pkg::PIN_IDLE;
            prev_reg <= eic_pkg::PIN_IDLE;
         end else begin
            sh_reg <= {sh_reg[1:0], ext_pin_in[g]};
            if (sh_reg[1] == sh_reg[2]) begin
               lvl_reg <= sh_reg[2];
            end
            prev_reg <= lvl_reg;
         end
      end
      assign lvl_w[g] = lvl_reg;
      assign edge_w[g] = (sense_w == eic_pkg::SENSE_RISE && lvl_reg && !prev_reg) ||
                         (sense_w == eic_pkg::SENSE_FALL && !lvl_reg && prev_reg);
      assign level_w[g] = (sense_w == eic_pkg::SENSE_LEVEL) && !lvl_w[g];
      assign w1c_w[g] = wr_w && addr_w == eic_pkg::OFF_FLAG &&
                        wd_w[eic_pkg::EXT_FIELD_LSB + g];
      assign clrv_w[g] = fire_w && (src_reg == 1'(g));

      // A new edge wins over a clear in the same cycle so no event is lost.
      always_ff @(posedge clk_in or negedge rstn_in) begin
         if (!rstn_in) begin
            flag_reg[g] <= eic_pkg::FLAG_RST[g];
         end else if (sense_w == eic_pkg::SENSE_LEVEL) begin
            flag_reg[g] <= 1'b0;
         end else if (edge_w[g]) begin
            flag_reg[g] <= 1'b1;
         end else if (clrv_w[g] || w1c_w[g]) begin
            flag_reg[g] <= 1'b0;
         end
      end
      assign req_w[g] = mask_reg[g] && (flag_reg[g] || level_w[g]);
   end

   // ****************************************
   // Entry sequencer
   // ****************************************
   assign accept_w = state_reg == eic_pkg::ST_IDLE && gie_reg && (|req_w) &&
                     boundary_in;
   assign fire_w = state_reg == eic_pkg::ST_ENTRY && cnt_reg == 8'h0;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg <= eic_pkg::ST_IDLE;
         cnt_reg <= 8'h0;
         src_reg <= 1'b0;
      end else begin
         case (state_reg)
            eic_pkg::ST_IDLE: begin
               if (accept_w) begin
                  state_reg <= eic_pkg::ST_ENTRY;
                  cnt_reg <= 8'(ENTRY_CYCLES - 2);
                  src_reg <= !req_w[0];
               end else if (return_from_irq_instr_in) begin
                  state_reg <= eic_pkg::ST_GAP;
               end
            end
            eic_pkg::ST_ENTRY: begin
               if (cnt_reg == 8'h0) begin
                  state_reg <= eic_pkg::ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h1;
               end
            end
            eic_pkg::ST_GAP: begin
               if (instr_done_in) begin
                  state_reg <= eic_pkg::ST_IDLE;
               end
            end
            default: state_reg <= eic_pkg::ST_IDLE;
         endcase
      end
   end

   // Only the program counter is pushed by the core; the status byte is left to software.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         vec_reg <= '0;
         take_reg <= 1'b0;
      end else begin
         take_reg <= accept_w;
         vec_reg.valid <= fire_w;
         if (fire_w) begin
            vec_reg.addr <= src_reg ? eic_pkg::VEC_ONE : eic_pkg::VEC_ZERO;
         end
      end
   end
   assign vec_out = vec_reg;
   assign take_out = take_reg;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         gie_reg <= eic_pkg::GIE_RST;
      end else if (return_from_irq_instr_in) begin
         gie_reg <= 1'b1;
      end else if (accept_w) begin
         gie_reg <= 1'b0;
      end else if (wr_w && addr_w == eic_pkg::OFF_PSTAT) begin
         gie_reg <= wd_w[eic_pkg::GIE_BIT];
      end
   end
   assign gie_out = gie_reg;

   // ****************************************
   // Interrupt status
   // ****************************************
   assign ev_w = {fire_w, edge_w};
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         istat_reg <= eic_pkg::IRQ_RST;
      end else if (wr_w && addr_w == eic_pkg::OFF_ICLR) begin
         istat_reg <= (istat_reg & ~wd_w[2:0]) | ev_w;
      end else begin
         istat_reg <= istat_reg | ev_w;
      end
   end
   assign irq_out = |(istat_reg & ien_reg);

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   a_gie_accept_clr: assert property (accept_w && !return_from_irq_instr_in |=> !gie_reg)
      else $error("Global enable not cleared on accept.");
   a_gie_return_from_irq_instr_set: assert property (return_from_irq_instr_in |=> gie_reg)
      else $error("Global enable not set on return.");
   a_vec_flag_clr: assert property (fire_w && !edge_w[src_reg] |=> !flag_reg[$past(src_reg)])
      else $error("Flag not cleared on vector.");
   a_flag_hold_masked: assert property (flag_reg[0] && !mask_reg[0] && !w1c_w[0] &&
      ctrl_reg[1:0] != eic_pkg::SENSE_LEVEL ##1 ctrl_reg[1:0] != eic_pkg::SENSE_LEVEL
      |-> flag_reg[0])
      else $error("Masked flag lost.");
   a_wait_no_gie: assert property (!gie_reg && state_reg == eic_pkg::ST_IDLE
      |=> state_reg != eic_pkg::ST_ENTRY)
      else $error("Served while globally disabled.");
   a_level_request: assert property (level_w[1] && mask_reg[1] |-> req_w[1])
      else $error("Level request missing.");
   a_vec_one_addr: assert property (fire_w && src_reg |=> vec_out.valid &&
      vec_out.addr == eic_pkg::VEC_ONE)
      else $error("Wrong vector for request one.");
   a_vec_zero_addr: assert property (fire_w && !src_reg |=> vec_out.addr == eic_pkg::VEC_ZERO)
      else $error("Wrong vector for request zero.");
   a_edge_sets_flag: assert property (edge_w[0] |=> flag_reg[0] ||
      ctrl_reg[1:0] == eic_pkg::SENSE_LEVEL)
      else $error("Edge did not set flag.");
   a_level_flag_zero: assert property (ctrl_reg[3:2] == eic_pkg::SENSE_LEVEL |=> !flag_reg[1])
      else $error("Flag set in level mode.");
   a_mask_rsv_zero: assert property (setup_w && !apb_in.pwrite && addr_w == eic_pkg::OFF_MASK
      |=> prdata_out[5:0] == 6'h0)
      else $error("Reserved mask bits not zero.");
   a_entry_min_time: assert property (accept_w |=> !vec_out.valid [*2])
      else $error("Vector too early.");
   a_gap_blocks: assert property (state_reg == eic_pkg::ST_GAP && !instr_done_in
      |=> !take_out && state_reg == eic_pkg::ST_GAP)
      else $error("Served before one instruction.");
   a_zero_priority: assert property (accept_w && req_w[0] |=> !src_reg)
      else $error("Priority order wrong.");

   c_vec_one: cover property (fire_w && src_reg);
   c_both_pending: cover property (accept_w && req_w == 2'h3);
   c_return_from_irq_instr_gap: cover property (state_reg == eic_pkg::ST_GAP ##1 state_reg == eic_pkg::ST_IDLE);

   // ****************************************
   // Sequencer and register checks
   // ****************************************
   a_take_after_accept: assert property (
      accept_w
      |=> take_out)
      else $error("Push start missing after accept.");
   a_take_one_cycle: assert property (
      take_out
      |=> !take_out)
      else $error("Push start longer than one cycle.");
   a_vec_one_cycle: assert property (
      vec_out.valid
      |=> !vec_out.valid)
      else $error("Vector strobe longer than one cycle.");
   a_vec_addr_hold: assert property (
      !fire_w
      |=> $stable(vec_out.addr))
      else $error("Vector address moved without a vector.");
   a_accept_needs_gie: assert property (
      accept_w
      |-> gie_reg && boundary_in)
      else $error("Accepted while globally disabled.");
   a_gap_after_return_from_irq_instr: assert property (
      state_reg == eic_pkg::ST_IDLE && return_from_irq_instr_in && !accept_w
      |=> state_reg == eic_pkg::ST_GAP)
      else $error("No gap after return.");
   a_gap_leaves: assert property (
      state_reg == eic_pkg::ST_GAP && instr_done_in
      |=> state_reg == eic_pkg::ST_IDLE)
      else $error("Gap not left after one instruction.");
   a_one_priority: assert property (
      accept_w && !req_w[0]
      |=> src_reg)
      else $error("Request one not chosen when alone.");
   a_level_request_zero: assert property (
      level_w[0] && mask_reg[0]
      |-> req_w[0])
      else $error("Level request zero missing.");
   a_flag_w1c_zero: assert property (
      w1c_w[0] && !edge_w[0]
      |=> !flag_reg[0])
      else $error("Flag zero not cleared by write.");
   a_flag_w1c_one: assert property (
      w1c_w[1] && !edge_w[1]
      |=> !flag_reg[1])
      else $error("Flag one not cleared by write.");
   a_flag_zero_write: assert property (
      wr_w && addr_w == eic_pkg::OFF_FLAG && !wd_w[eic_pkg::EXT_FIELD_LSB] &&
      flag_reg[0] && !clrv_w[0] &&
      ctrl_reg[1:0] != eic_pkg::SENSE_LEVEL
      |=> flag_reg[0])
      else $error("Writing zero cleared a flag.");
   a_level_flag_zero0: assert property (
      ctrl_reg[1:0] == eic_pkg::SENSE_LEVEL
      |=> !flag_reg[0])
      else $error("Flag zero set in level mode.");
   a_edge_sets_one: assert property (
      edge_w[1]
      |=> flag_reg[1] || ctrl_reg[3:2] == eic_pkg::SENSE_LEVEL)
      else $error("Edge did not set flag one.");
   a_flag_rsv_zero: assert property (
      setup_w && !apb_in.pwrite && addr_w == eic_pkg::OFF_FLAG
      |=> prdata_out[5:0] == 6'h0)
      else $error("Reserved flag bits not zero.");
   a_rsv_high_zero: assert property (
      setup_w && !apb_in.pwrite &&
      (addr_w == eic_pkg::OFF_MASK || addr_w == eic_pkg::OFF_FLAG)
      |=> prdata_out[31:8] == 24'h0)
      else $error("Upper register bits not zero.");
   a_mask_hold: assert property (
      !wr_w
      |=> $stable(mask_reg))
      else $error("Mask changed without a write.");
   a_gie_write_set: assert property (
      wr_w && addr_w == eic_pkg::OFF_PSTAT && wd_w[eic_pkg::GIE_BIT] && !accept_w
      |=> gie_reg)
      else $error("Software set of global enable lost.");
   a_istat_vec_event: assert property (
      vec_out.valid
      |-> istat_reg[2])
      else $error("Vector event not recorded.");
   a_irq_needs_status: assert property (
      irq_out
      |-> |istat_reg)
      else $error("Interrupt line high with no status.");

   c_level_one: cover property (accept_w && !req_w[0] && level_w[1]);
   c_flag_w1c: cover property (w1c_w[0] ##1 !flag_reg[0]);
endmodule

// ### verif/eic_core_model.sv
`timescale 1ns/1ns
module eic_core_model (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire eic_pkg::eic_vec_s vec_in,
   input wire logic [3:0] wait_in,
   output logic boundary_out,
   output logic return_from_irq_instr_out,
   output logic done_out
);
   // ****************************************
   // Handler run, return and one main instruction
   // ****************************************
   logic busy_reg;
   logic [3:0] cnt_reg;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         busy_reg <= 1'b0;
         cnt_reg <= 4'h0;
         return_from_irq_instr_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         return_from_irq_instr_out <= 1'b0;
         done_out <= return_from_irq_instr_out;
         if (vec_in.valid) begin
            busy_reg <= 1'b1;
            cnt_reg <= wait_in;
         end else if (busy_reg && cnt_reg == 4'h0) begin
            busy_reg <= 1'b0;
            return_from_irq_instr_out <= 1'b1;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
         end
      end
   end
   // The core is never at a boundary while a handler runs.
   assign boundary_out = !busy_reg;
endmodule

// ### verif/ext_interrupt_control_bench.sv
`timescale 1ns/1ns
module ext_interrupt_control_bench;
   localparam int EC = 4;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   eic_pkg::eic_apb_s apb_r = '0;
   logic [1:0] pin_r = 2'h3;
   logic [3:0] wait_r = 4'h2;
   logic [31:0] prdata;
   logic pready, pslverr, take, gie, irq, bnd, return_from_irq_instr, done;
   eic_pkg::eic_vec_s vec;
   int errors = 0;
   int compares = 0;
   logic [31:0] q;
   logic e;
   int n;
   initial begin
      forever #20 clk_in = ~clk_in;
   end
   eic_top #(.ENTRY_CYCLES(EC)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .apb_in(apb_r),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .ext_pin_in(pin_r),
      .boundary_in(bnd), .return_from_irq_instr_in(return_from_irq_instr), .instr_done_in(done), .take_out(take),
      .vec_out(vec), .gie_out(gie), .irq_out(irq));
   eic_core_model core_u (.clk_in(clk_in), .rstn_in(rstn_in), .vec_in(vec),
      .wait_in(wait_r), .boundary_out(bnd), .return_from_irq_instr_out(return_from_irq_instr), .done_out(done));
   // ****************************************
   // Tasks
   // ****************************************
   task stop_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input string s, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         errors++;
         $display("unexpected %s expected %h seen %h", s, x, g);
      end
   endtask
   // Each call starts just after an edge and ends one idle edge later.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      apb_r <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk_in);
      apb_r.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         errors++;
         stop_test;
      end
      q = prdata;
      e = pslverr;
      apb_r.psel <= 1'b0;
      apb_r.penable <= 1'b0;
      @(posedge clk_in);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), x, q);
   endtask
   task tick(input int c);
      repeat (c) @(posedge clk_in);
   endtask
   task pulse;
      pin_r <= 2'h0;
      tick(8);
      pin_r <= 2'h3;
      tick(8);
   endtask
   // Counts edges from the push start to the vector strobe.
   task wait_vec(output int c);
      int k;
      k = 0;
      c = 0;
      while (take !== 1'b1 && k < 300) begin
         @(posedge clk_in);
         k++;
      end
      while (vec.valid !== 1'b1 && k < 300) begin
         @(posedge clk_in);
         c++;
         k++;
      end
      if (k >= 300) begin
         errors++;
         stop_test;
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      tick(20);
      rstn_in <= 1'b1;
      tick(1);
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), 32'h0);
      end
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      wr(eic_pkg::OFF_MASK, 32'hFFFF_FFFF);
      rd(eic_pkg::OFF_MASK, 32'hC0);
      wr(eic_pkg::OFF_MASK, 32'h0);
      wr(eic_pkg::OFF_CTRL, 32'h0E);
      pulse;
      rd(eic_pkg::OFF_FLAG, 32'hC0);
      rd(eic_pkg::OFF_ISTAT, 32'h3);
      wr(eic_pkg::OFF_FLAG, 32'h0);
      rd(eic_pkg::OFF_FLAG, 32'hC0);
      wr(eic_pkg::OFF_CTRL, 32'h02);
      rd(eic_pkg::OFF_FLAG, 32'h40);
      wr(eic_pkg::OFF_FLAG, 32'h40);
      rd(eic_pkg::OFF_FLAG, 32'h0);
      pulse;
      rd(eic_pkg::OFF_FLAG, 32'h40);
      wr(eic_pkg::OFF_IEN, 32'h1);
      chk("irq enabled", 32'h1, {31'h0, irq});
      wr(eic_pkg::OFF_IEN, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(eic_pkg::OFF_ICLR, 32'h3);
      rd(eic_pkg::OFF_ISTAT, 32'h0);
      wr(eic_pkg::OFF_IEN, 32'h3);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(eic_pkg::OFF_MASK, 32'hC0);
      pin_r <= 2'h1;
      tick(8);
      rd(eic_pkg::OFF_FLAG, 32'h40);
      wr(eic_pkg::OFF_PSTAT, 32'h80);
      wait_vec(n);
      wait_r <= 4'hF;
      chk("entry cycles", 32'(EC - 1), 32'(n));
      chk("first vector", 32'h001, {20'h0, vec.addr});
      chk("enable after entry", 32'h0, {31'h0, gie});
      wait_vec(n);
      chk("second vector", 32'h002, {20'h0, vec.addr});
      pin_r <= 2'h3;
      tick(30);
      rd(eic_pkg::OFF_PSTAT, 32'h80);
      rd(eic_pkg::OFF_FLAG, 32'h0);
      stop_test;
   end
endmodule
